// [tpf_params.svh]
// Offsets, field positions, reset values and fixed codes of the filter configuration block
`ifndef TPF_PARAMS_SVH
`define TPF_PARAMS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define TPF_OFS_SLOT0 8'h00
`define TPF_OFS_BYPASS 8'h1c
`define TPF_OFS_PRELOAD 8'h20
`define TPF_OFS_MONITOR 8'h24
// ==========================================================
// Field positions
`define TPF_EN_BIT 24
`define TPF_KIND_MSB 23
`define TPF_KIND_LSB 16
`define TPF_PID_MSB 12
`define TPF_STORE_BIT 24
`define TPF_TRIG_BIT 30
`define TPF_VAL_MSB 29
`define TPF_MON_SEND_BIT 31
`define TPF_MON_FETCH_BIT 30
// ==========================================================
// Writable-bit masks and reset values
`define TPF_SLOT_MASK 32'h01ff1fff
`define TPF_BYPASS_MASK 32'h01000000
`define TPF_RST_SLOT 32'h00000000
`define TPF_RST_BYPASS 32'h00000000
`define TPF_RST_PRELOAD 30'h00000000
`define TPF_RST_STAMP 30'h00000000
// ==========================================================
// Fixed codes
`define TPF_OTHER_CHAN 3'h7
`define TPF_MAX_SLOTS 7
`endif

// [tpf_pkg.sv]
// Types shared by the filter configuration block
package tpf_pkg;
    // ==========================================================
    // Transmit stamp sequence states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARM   = 4'b0010,
        ST_FETCH = 4'b0100,
        ST_SEND  = 4'b1000
    } tpf_tx_state_e;
endpackage

// [tpf_buf2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module tpf_buf2 #(
    parameter int W = 43
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    if (W < 1) begin : g_bad_width
        $error("W must be at least 1");
    end

    logic [W-1:0] e0_q, e0_d, e1_q, e1_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = e0_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        e0_d = e0_q;
        e1_d = e1_q;
        cnt_d = cnt_q;
        case ({push, pop})
            2'b10: begin
                if (cnt_q == 2'h0) begin
                    e0_d = in_data;
                end else begin
                    e1_d = in_data;
                end
                cnt_d = cnt_q + 2'h1;
            end
            2'b01: begin
                e0_d = e1_q;
                cnt_d = cnt_q - 2'h1;
            end
            2'b11: begin
                if (cnt_q == 2'h1) begin
                    e0_d = in_data;
                end else begin
                    e0_d = e1_q;
                    e1_d = in_data;
                end
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            e0_q <= '0;
            e1_q <= '0;
            cnt_q <= 2'h0;
        end else begin
            e0_q <= e0_d;
            e1_q <= e1_d;
            cnt_q <= cnt_d;
        end
    end
endmodule // tpf_buf2

// [tpf_cfg_top.sv]
// Packet filter slots, passthrough store enable and transmit stamp sequencing
`timescale 1ns/1ps
`include "tpf_params.svh"
module tpf_cfg_top #(
    parameter int NUM_SLOTS = 7
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Incoming packet words
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic rx_sop,
    input wire logic [12:0] rx_pid,
    input wire logic [31:0] rx_data,
    input wire logic bypass_mode,
    // Memory write side
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [31:0] wr_data,
    output logic [2:0] wr_chan,
    output logic [7:0] wr_kind,
    // Transmit stamp sequence
    input wire logic tx_buf_load,
    input wire logic tx_pkt_ready,
    output logic stamp_load_pulse,
    output logic fetch_req,
    output logic tx_send,
    output logic [29:0] arrival_time_stamp
);
    // ==========================================================
    // Elaboration check
    if (NUM_SLOTS < 1 || NUM_SLOTS > `TPF_MAX_SLOTS) begin : g_bad_slots
        $error("NUM_SLOTS must be 1 to 7, channel 7 is kept for other data");
    end

    // ==========================================================
    // Register file
    logic [31:0] slot_q [NUM_SLOTS];
    logic [31:0] slot_d [NUM_SLOTS];
    logic [31:0] bypass_q, bypass_d;
    logic [29:0] preload_q, preload_d;
    logic pulse_q, pulse_d;
    logic [31:0] rdata_q, rdata_d;
    logic [29:0] stamp_q, stamp_d;
    tpf_pkg::tpf_tx_state_e st_q, st_d;
    logic trig_wr;

    assign trig_wr = reg_wr && (reg_addr == `TPF_OFS_PRELOAD) && reg_wdata[`TPF_TRIG_BIT];

    always_comb begin
        for (int i = 0; i < NUM_SLOTS; i++) begin
            slot_d[i] = slot_q[i];
            if (reg_wr && reg_addr == (`TPF_OFS_SLOT0 + 8'(4 * i))) begin
                slot_d[i] = reg_wdata & `TPF_SLOT_MASK;
            end
        end
        bypass_d = bypass_q;
        if (reg_wr && reg_addr == `TPF_OFS_BYPASS) begin
            bypass_d = reg_wdata & `TPF_BYPASS_MASK;
        end
        preload_d = preload_q;
        if (reg_wr && reg_addr == `TPF_OFS_PRELOAD) begin
            preload_d = reg_wdata[`TPF_VAL_MSB:0];
        end
        pulse_d = trig_wr;
        rdata_d = 32'h0;
        if (reg_rd) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (reg_addr == (`TPF_OFS_SLOT0 + 8'(4 * i))) begin
                    rdata_d = slot_q[i];
                end
            end
            if (reg_addr == `TPF_OFS_PRELOAD) begin
                rdata_d = {2'b00, preload_q};
            end
            if (reg_addr == `TPF_OFS_BYPASS) begin
                rdata_d = bypass_q;
            end
            if (reg_addr == `TPF_OFS_MONITOR) begin
                rdata_d = {tx_send, fetch_req, stamp_q};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_q[i] <= `TPF_RST_SLOT;
            end
            bypass_q <= `TPF_RST_BYPASS;
            preload_q <= `TPF_RST_PRELOAD;
            pulse_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_q[i] <= slot_d[i];
            end
            bypass_q <= bypass_d;
            preload_q <= preload_d;
            pulse_q <= pulse_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign stamp_load_pulse = pulse_q;

    // ==========================================================
    // Packet classification
    logic [NUM_SLOTS-1:0] hit;
    logic [2:0] hit_chan, cur_chan, chan_q, chan_d;
    logic [7:0] hit_kind, cur_kind, kind_q, kind_d;
    logic drop, buf_in_valid, buf_in_ready;
    logic [42:0] buf_out;

    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
        assign hit[i] = slot_q[i][`TPF_EN_BIT] && (slot_q[i][`TPF_PID_MSB:0] == rx_pid);
    end

    always_comb begin
        hit_chan = `TPF_OTHER_CHAN;
        hit_kind = 8'h00;
        // Lowest slot wins when two enabled slots share a packet id
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_chan = 3'(i);
                hit_kind = slot_q[i][`TPF_KIND_MSB:`TPF_KIND_LSB];
            end
        end
        if (bypass_mode) begin
            hit_chan = `TPF_OTHER_CHAN;
            hit_kind = 8'h00;
        end
    end

    // Tag is taken from the header word and held for the rest of the packet
    assign cur_chan = rx_sop ? hit_chan : chan_q;
    assign cur_kind = rx_sop ? hit_kind : kind_q;
    assign drop = bypass_mode && !bypass_q[`TPF_STORE_BIT];
    assign buf_in_valid = rx_valid && !drop;
    // Dropped words are still accepted so the source never hangs
    assign rx_ready = drop ? 1'b1 : buf_in_ready;

    always_comb begin
        chan_d = chan_q;
        kind_d = kind_q;
        if (rx_valid && rx_ready && rx_sop) begin
            chan_d = hit_chan;
            kind_d = hit_kind;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chan_q <= `TPF_OTHER_CHAN;
            kind_q <= 8'h00;
        end else begin
            chan_q <= chan_d;
            kind_q <= kind_d;
        end
    end

    tpf_buf2 #(
        .W(43)
    ) u_buf (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data({cur_kind, cur_chan, rx_data}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(buf_out)
    );

    // Kind, channel and word leave the buffer flops together
    assign {wr_kind, wr_chan, wr_data} = buf_out;

    // ==========================================================
    // Transmit stamp sequence
    always_comb begin
        st_d = st_q;
        stamp_d = stamp_q;
        case (st_q)
            tpf_pkg::ST_IDLE: begin
                stamp_d = stamp_q + 30'h1;
            end
            tpf_pkg::ST_ARM: begin
                if (tx_buf_load) begin
                    stamp_d = preload_q;
                    st_d = tpf_pkg::ST_FETCH;
                end
            end
            tpf_pkg::ST_FETCH: begin
                stamp_d = stamp_q + 30'h1;
                if (tx_pkt_ready) begin
                    st_d = tpf_pkg::ST_SEND;
                end
            end
            tpf_pkg::ST_SEND: begin
                stamp_d = stamp_q + 30'h1;
            end
            default: begin
                st_d = tpf_pkg::ST_IDLE;
            end
        endcase
        // A new trigger restarts the sequence from any state
        if (pulse_q) begin
            st_d = tpf_pkg::ST_ARM;
            stamp_d = stamp_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= tpf_pkg::ST_IDLE;
            stamp_q <= `TPF_RST_STAMP;
        end else begin
            st_q <= st_d;
            stamp_q <= stamp_d;
        end
    end

    assign fetch_req = (st_q == tpf_pkg::ST_FETCH);
    assign tx_send = (st_q == tpf_pkg::ST_SEND);
    assign arrival_time_stamp = stamp_q;

    // ==========================================================
    // Assertions
    a_slot_write_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == `TPF_OFS_SLOT0)
        |=> slot_q[0] == ($past(reg_wdata) & `TPF_SLOT_MASK))
        else $error("slot 0 did not keep written value");
    a_slot_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `TPF_OFS_SLOT0)
        |=> reg_rdata[31:25] == 7'h0 && reg_rdata[15:13] == 3'h0
            && reg_rdata[23:16] == slot_q[0][23:16])
        else $error("slot read shows reserved bits or wrong kind");
    a_pulse_single: assert property (@(posedge core_clk) disable iff (!rst_n)
        trig_wr ##1 !trig_wr |=> !stamp_load_pulse)
        else $error("load pulse longer than one clock");
    a_pulse_after_trig: assert property (@(posedge core_clk) disable iff (!rst_n)
        stamp_load_pulse == $past(trig_wr))
        else $error("load pulse not tied to trigger write");
    a_trig_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `TPF_OFS_PRELOAD) |=> !reg_rdata[`TPF_TRIG_BIT])
        else $error("trigger bit read back");
    a_stamp_loads: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == tpf_pkg::ST_ARM && tx_buf_load && !pulse_q)
        |=> arrival_time_stamp == $past(preload_q) ##1 arrival_time_stamp == $past(preload_q, 2) + 30'h1)
        else $error("stamp counter not loaded then counting");
    a_fetch_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(fetch_req) |-> $past(st_q == tpf_pkg::ST_ARM && tx_buf_load))
        else $error("fetch request without counter load");
    a_send_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fetch_req && tx_pkt_ready && !pulse_q) |=> tx_send && !fetch_req)
        else $error("send not started on first packet ready");
    a_other_chan: assert property (@(posedge core_clk) disable iff (!rst_n)
        (buf_in_valid && rx_sop && hit == '0) |-> cur_chan == `TPF_OTHER_CHAN)
        else $error("unmatched packet not on channel 7");
    a_bypass_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bypass_mode && !bypass_q[`TPF_STORE_BIT]) |-> !buf_in_valid && rx_ready)
        else $error("passthrough input stored while disabled");
    a_match_chan: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rx_sop && !bypass_mode && hit[0]) |-> cur_chan == 3'h0
            && cur_kind == slot_q[0][`TPF_KIND_MSB:`TPF_KIND_LSB])
        else $error("slot 0 match not routed to channel 0");
    a_store_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bypass_mode && bypass_q[`TPF_STORE_BIT]) |-> buf_in_valid == rx_valid)
        else $error("passthrough input dropped while store enabled");
    a_arm_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == tpf_pkg::ST_ARM && !tx_buf_load && !pulse_q)
        |=> arrival_time_stamp == $past(arrival_time_stamp))
        else $error("stamp counter moved while waiting for load");
    a_fetch_counts: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fetch_req && !pulse_q) |=> arrival_time_stamp == $past(arrival_time_stamp) + 30'h1)
        else $error("stamp counter not counting after load");
    a_send_counts: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tx_send && !pulse_q) |=> arrival_time_stamp == $past(arrival_time_stamp) + 30'h1)
        else $error("stamp counter not counting while sending");
    a_enabled_route: assert property (@(posedge core_clk) disable iff (!rst_n)
        (buf_in_valid && rx_sop && !bypass_mode && hit != '0) |-> cur_chan != `TPF_OTHER_CHAN)
        else $error("matched packet sent to the catch-all channel");
endmodule // tpf_cfg_top

// [tpf_mem_model.sv]
// Memory-side sink model that takes stored words and may stall
`timescale 1ns/1ps
module tpf_mem_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pace: 0 prompt, 1 slow, 2 stalled
    input wire logic [1:0] pace,
    // Write side of the block
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [31:0] wr_data,
    input wire logic [2:0] wr_chan,
    input wire logic [7:0] wr_kind
);
    // ==========================================================
    // Capture of taken words
    logic [42:0] got[$];
    logic tgl_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tgl_q <= 1'b0;
        end else begin
            tgl_q <= !tgl_q;
        end
    end
    // Plain always: the bench also empties this queue between scenarios
    always @(posedge core_clk) begin
        if (rst_n && wr_valid && wr_ready) begin
            got.push_back({wr_kind, wr_chan, wr_data});
        end
    end
    // Slow pace accepts every other cycle to exercise the buffer
    assign wr_ready = (pace == 2'h0) || (pace == 2'h1 && tgl_q);
endmodule // tpf_mem_model

// [testbench.sv]
// Register and stream tests of the filter configuration block
`timescale 1ns/1ps
`include "tpf_params.svh"
module testbench;
    // ==========================================================
    // Signals
    logic core_clk, rst_n, reg_wr, reg_rd, rx_valid, rx_ready, rx_sop, bypass_mode;
    logic wr_valid, wr_ready, tx_buf_load, tx_pkt_ready, stamp_load_pulse, fetch_req, tx_send;
    logic [7:0] reg_addr, wr_kind;
    logic [31:0] reg_wdata, reg_rdata, rx_data, wr_data;
    logic [12:0] rx_pid;
    logic [2:0] wr_chan;
    logic [29:0] arrival_time_stamp, t;
    logic [1:0] pace;
    logic [12:0] pid_t[7];
    logic [7:0] kind_t[7];
    logic en_t[7];
    logic [10:0] cur_tag;
    logic store_on;
    logic [42:0] exp_q[$];
    int n_mismatch = 0;
    int checks_done = 0;
    int n;
    localparam logic [29:0] SV = 30'h2abcdef0;

    tpf_cfg_top #(.NUM_SLOTS(7)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_sop(rx_sop),
        .rx_pid(rx_pid), .rx_data(rx_data), .bypass_mode(bypass_mode),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_chan(wr_chan),
        .wr_kind(wr_kind), .tx_buf_load(tx_buf_load), .tx_pkt_ready(tx_pkt_ready),
        .stamp_load_pulse(stamp_load_pulse), .fetch_req(fetch_req), .tx_send(tx_send),
        .arrival_time_stamp(arrival_time_stamp));
    tpf_mem_model mem (.core_clk(core_clk), .rst_n(rst_n), .pace(pace),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .wr_chan(wr_chan), .wr_kind(wr_kind));

    // ==========================================================
    // Helpers
    task chk(input string nm, input logic [42:0] e, input logic [42:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk("reg_rdata", e, reg_rdata);
    endtask
    // Lowest enabled matching slot wins, else the catch-all channel
    function automatic logic [10:0] tag(input logic [12:0] p);
        tag = {8'h00, `TPF_OTHER_CHAN};
        for (int i = 6; i >= 0; i--) begin
            if (en_t[i] && pid_t[i] == p) begin
                tag = {kind_t[i], 3'(i)};
            end
        end
    endfunction
    task send(input logic sop, input logic [12:0] p, input logic [31:0] d);
        int k;
        logic ok;
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_sop <= sop;
        rx_pid <= p;
        rx_data <= d;
        k = 0;
        // Ready is looked at while settled, before the edge that takes the word
        do begin
            @(negedge core_clk);
            ok = rx_ready;
            @(posedge core_clk);
            k++;
        end while (ok !== 1'b1 && k < 50);
        rx_valid <= 1'b0;
        chk("rx_ready", 1, 43'(ok));
        if (sop) begin
            cur_tag = bypass_mode ? {8'h00, `TPF_OTHER_CHAN} : tag(p);
        end
        if (!bypass_mode || store_on) begin
            exp_q.push_back({cur_tag, d});
        end
    endtask
    task drain_cmp();
        int k;
        k = 0;
        repeat (6) @(posedge core_clk);
        while (mem.got.size() < exp_q.size() && k < 300) begin
            @(posedge core_clk);
            k++;
        end
        chk("stored_count", 43'(exp_q.size()), 43'(mem.got.size()));
        while (exp_q.size() > 0 && mem.got.size() > 0) begin
            chk("stored_word", exp_q.pop_front(), mem.got.pop_front());
        end
        exp_q.delete();
        mem.got.delete();
    endtask
    task print_verdict();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = !core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        print_verdict();
    end

    // ==========================================================
    // Test sequence
    initial begin
        {rst_n, reg_wr, reg_rd, rx_valid, rx_sop, bypass_mode, tx_buf_load, tx_pkt_ready} = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        rx_pid = 13'h0;
        rx_data = 32'h0;
        pace = 2'h0;
        store_on = 1'b0;
        cur_tag = 11'h0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk("fetch_after_reset", 0, fetch_req);
        chk("send_after_reset", 0, tx_send);
        for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0);
        // Reserved bits and unmapped places read zero
        for (int i = 0; i < 7; i++) begin
            wr(8'(4 * i), 32'hffffffff);
            rd(8'(4 * i), `TPF_SLOT_MASK);
        end
        wr(`TPF_OFS_BYPASS, 32'hffffffff);
        rd(`TPF_OFS_BYPASS, `TPF_BYPASS_MASK);
        wr(`TPF_OFS_BYPASS, 32'h0);
        wr(8'h30, 32'hffffffff);
        rd(8'h30, 32'h0);
        // Stamp sequence from trigger to sending
        wr(`TPF_OFS_PRELOAD, {2'h3, SV});
        @(negedge core_clk);
        chk("load_pulse", 1, stamp_load_pulse);
        @(negedge core_clk);
        chk("load_pulse_end", 0, stamp_load_pulse);
        t = arrival_time_stamp;
        @(negedge core_clk);
        chk("stamp_held", 43'(t), 43'(arrival_time_stamp));
        rd(`TPF_OFS_PRELOAD, {2'h0, SV});
        @(posedge core_clk);
        tx_buf_load <= 1'b1;
        @(posedge core_clk);
        tx_buf_load <= 1'b0;
        @(negedge core_clk);
        chk("stamp_loaded", 43'(SV), 43'(arrival_time_stamp));
        chk("fetch_req", 1, fetch_req);
        @(posedge core_clk);
        tx_pkt_ready <= 1'b1;
        @(posedge core_clk);
        tx_pkt_ready <= 1'b0;
        @(negedge core_clk);
        chk("tx_send", 1, tx_send);
        chk("fetch_done", 0, fetch_req);
        chk("stamp_runs", 43'(SV + 30'h2), 43'(arrival_time_stamp));
        rd(`TPF_OFS_MONITOR, {2'b10, SV + 30'h3});
        // Slot routing, slot 3 disabled, slot 6 duplicates slot 4
        for (int i = 0; i < 7; i++) begin
            pid_t[i] = (i == 6) ? 13'h104 : 13'(13'h100 + i);
            kind_t[i] = 8'(8'h10 + i);
            en_t[i] = (i != 3);
            wr(8'(4 * i), {7'h0, en_t[i], kind_t[i], 3'h0, pid_t[i]});
        end
        pace <= 2'h1;
        for (int i = 0; i < 8; i++) begin
            send(1'b1, 13'(13'h100 + i), 32'(32'ha0 + i));
            send(1'b0, 13'h1fff, 32'(32'hb0 + i));
        end
        drain_cmp();
        // Buffer fills while memory stalls, then drains
        pace <= 2'h2;
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_sop <= 1'b1;
        rx_pid <= pid_t[0];
        rx_data <= 32'hf0;
        n = 0;
        repeat (6) begin
            @(negedge core_clk);
            if (rx_ready === 1'b1) n++;
            @(posedge core_clk);
        end
        rx_valid <= 1'b0;
        chk("taken_while_stalled", 2, 43'(n));
        repeat (2) exp_q.push_back({kind_t[0], 3'h0, 32'hf0});
        pace <= 2'h1;
        drain_cmp();
        // Passthrough: dropped while store is off, channel 7 when on
        bypass_mode <= 1'b1;
        send(1'b1, pid_t[0], 32'hc0);
        drain_cmp();
        wr(`TPF_OFS_BYPASS, 32'h01000000);
        store_on = 1'b1;
        send(1'b1, pid_t[1], 32'hd1);
        send(1'b0, pid_t[1], 32'hd2);
        drain_cmp();
        print_verdict();
    end
endmodule // testbench
